/* ddifd_top.sv */
// Purpose: decode five digital input terminals into drive commands
// Assumes: APB slave, zero wait states, terminals synchronous to pclk
// Notes: frozen values live in registers software may save and restore
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ddifd_top
  import ddifd_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_TERM-1:0] din,
  input wire logic alarm_active,
  input wire logic trip_locked,
  input wire logic [VAL_W-1:0] ref_now,
  input wire logic [VAL_W-1:0] freq_now,
  output logic alarm_clear,
  output logic coast,
  output logic quick_stop,
  output logic dc_hold_brake,
  output logic ramp_stop,
  output logic run,
  output logic reverse,
  output logic inch_override,
  output logic ref_frozen,
  output logic out_frozen,
  output logic [VAL_W-1:0] ref_hold,
  output logic [VAL_W-1:0] freq_hold,
  output logic [AUX_W-1:0] aux_level
);
  logic [NUM_TERM-1:0][SEL_W-1:0] sel;
  logic [3:0] ctrl;
  logic [NUM_TERM-1:0][SEL_W-1:0] code;
  logic [NUM_TERM-1:0] din_q;
  logic [NUM_TERM-1:0] rise;
  logic [NUM_TERM-1:0] fall;
  logic coast_c, quick_c, dcb_c, stop_c, halt_c, start_c, rev_c, jog_c, clr_c;
  logic hold_ref_c, hold_out_c, up_c, dn_c;
  logic [AUX_W-1:0] aux_c;
  ddifd_latch_type ls, next_ls;
  logic next_run;
  logic wr, rd_setup, hit;
  ddifd_qual_if #(.N(NUM_TERM)) qif ();

  // code legal on terminal t (0-based)?
  function automatic logic code_ok(input logic [SEL_W-1:0] c, input int t, input logic pout);
    logic ok;
    ok = (c <= FN_ENC_IN) && (c != 6'h12) && (c != FN_GAP);
    if (c == FN_ACCURATE_HALT_LOW || c == FN_PRECISE_SS) begin
      ok = (t < 2);
    end
    if (c == FN_PULSE_REF || c == FN_PULSE_FB) begin
      ok = (t == 4) || (t == 3 && !pout);
    end
    if (c == FN_PULSE_IN) begin
      ok = (t == 4);
    end
    if (c >= FN_ENC_REF && c <= FN_ENC_IN) begin
      ok = (t >= 3);
    end
    return ok;
  endfunction : code_ok

  // any terminal carrying function fn shows v high
  function automatic logic any_fn(input logic [NUM_TERM-1:0][SEL_W-1:0] cs,
                                  input logic [NUM_TERM-1:0] v, input logic [SEL_W-1:0] fn);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      r = r | ((cs[i] == fn) & v[i]);
    end
    return r;
  endfunction : any_fn

  // one step per qualified pulse, down wins, saturating both ways
  function automatic logic [VAL_W-1:0] step(input logic [VAL_W-1:0] v, input logic up,
                                            input logic dn);
    logic [VAL_W-1:0] r;
    r = v;
    if (dn) begin
      r = (v == '0) ? v : v - 1'b1;
    end else if (up) begin
      r = (v == '1) ? v : v + 1'b1;
    end
    return r;
  endfunction : step

  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      code[i] = code_ok(sel[i], i, ctrl[CTRL_PULSE_OUT]) ? sel[i] : FN_NONE;
    end
  end

  assign rise = din & ~din_q;
  assign fall = ~din & din_q;
  assign qif.level = din;

  ddifd_qual #(.N(NUM_TERM), .MIN_CYC(PULSE_CYC)) u_qual (
    .pclk(pclk),
    .presetn(presetn),
    .q(qif.qualifier)
  );

  always_comb begin
    coast_c = any_fn(code, ~din, FN_COAST_LOW) | any_fn(code, ~din, FN_CLEAR_AND_FREEWHEEL_LOW);
    quick_c = any_fn(code, ~din, FN_QSTOP_LOW);
    dcb_c = any_fn(code, ~din, FN_DC_HOLD_BRAKE_LOW) & ctrl[CTRL_DCB_TIME_NZ]
            & ctrl[CTRL_DCB_VOLT_NZ];
    stop_c = any_fn(code, ~din, FN_STOP_LOW) | any_fn(code, ~din, FN_ACCURATE_HALT_LOW);
    halt_c = coast_c | quick_c | dcb_c | stop_c;
    start_c = any_fn(code, din, FN_START)
              | (any_fn(code, din, FN_START_REV) & ~ctrl[CTRL_CLOSED_LOOP])
              | any_fn(code, din, FN_FWD_ONLY) | any_fn(code, din, FN_REV_ONLY)
              | any_fn(code, din, FN_RESET_START);
    if (any_fn(code, din, FN_REV_ONLY)) begin
      rev_c = 1'b1;
    end else if (any_fn(code, din, FN_FWD_ONLY)) begin
      rev_c = 1'b0;
    end else begin
      rev_c = (any_fn(code, din, FN_REVERSE) | any_fn(code, din, FN_START_REV))
              & ~ctrl[CTRL_CLOSED_LOOP];
    end
    jog_c = any_fn(code, din, FN_INCH_OVERRIDE) & ~(coast_c | quick_c | dcb_c);
    // trip-locked alarms only clear by a power cycle, so the pin path is blocked
    clr_c = (any_fn(code, rise, FN_RESET) | any_fn(code, fall, FN_CLEAR_AND_FREEWHEEL_LOW)
             | any_fn(code, rise, FN_RESET_START)) & alarm_active & ~trip_locked;
    hold_ref_c = any_fn(code, din, FN_HOLD_REF);
    hold_out_c = any_fn(code, din, FN_HOLD_OUT);
    up_c = any_fn(code, qif.long_pulse, FN_SPEED_UP);
    dn_c = any_fn(code, qif.long_pulse, FN_SPEED_DOWN);
    for (int k = 0; k < AUX_W; k++) begin
      aux_c[k] = any_fn(code, din, FN_AUX_BASE + SEL_W'(k));
    end
  end

  always_comb begin
    next_ls = ls;
    case (ls)
      LS_IDLE: begin
        if (any_fn(code, qif.long_pulse, FN_LATCH_START) && !halt_c) begin
          next_ls = LS_RUN;
        end
      end
      LS_RUN: begin
        if (halt_c || !any_fn(code, '1, FN_LATCH_START)) begin
          next_ls = LS_IDLE;
        end
      end
      default: next_ls = LS_IDLE;
    endcase
  end

  always_comb begin
    if (out_frozen) begin
      next_run = (run | start_c | (next_ls == LS_RUN)) & ~(coast_c | quick_c | dcb_c);
    end else begin
      next_run = (start_c | (next_ls == LS_RUN)) & ~halt_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls <= LS_IDLE;
      din_q <= '0;
    end else begin
      ls <= next_ls;
      din_q <= din;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_clear <= 1'b0;
      coast <= 1'b0;
      quick_stop <= 1'b0;
      dc_hold_brake <= 1'b0;
      ramp_stop <= 1'b0;
      run <= 1'b0;
      reverse <= 1'b0;
      inch_override <= 1'b0;
      aux_level <= '0;
    end else begin
      alarm_clear <= clr_c;
      coast <= coast_c;
      quick_stop <= quick_c;
      dc_hold_brake <= dcb_c;
      ramp_stop <= stop_c;
      run <= next_run;
      reverse <= rev_c;
      inch_override <= jog_c;
      aux_level <= aux_c;
    end
  end

  // apb: zero wait, read data registered in the setup cycle
  assign pready = 1'b1;
  assign hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_AUX);
  assign pslverr = psel & penable & ~hit;
  assign wr = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;

  // freeze registers: capture on entry, steps while held, value kept after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_frozen <= 1'b0;
      ref_hold <= '0;
    end else begin
      ref_frozen <= hold_ref_c;
      if (hold_ref_c && !ref_frozen) begin
        ref_hold <= ref_now;
      end else if (hold_ref_c) begin
        ref_hold <= step(ref_hold, up_c, dn_c);
      end else if (wr && paddr == OFS_FREF) begin
        ref_hold <= pwdata[VAL_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_frozen <= 1'b0;
      freq_hold <= '0;
    end else begin
      out_frozen <= hold_out_c;
      if (hold_out_c && !out_frozen) begin
        freq_hold <= freq_now;
      end else if (hold_out_c) begin
        freq_hold <= step(freq_hold, up_c, dn_c);
      end else if (wr && paddr == OFS_FOUT) begin
        freq_hold <= pwdata[VAL_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= SEL_RESET;
      ctrl <= CTRL_RESET;
    end else if (wr) begin
      if (paddr < OFS_CTRL) begin
        sel[paddr[4:2]] <= pwdata[SEL_W-1:0];
      end else if (paddr == OFS_CTRL) begin
        ctrl <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= '0;
      if (paddr[1:0] == 2'b00) begin
        if (paddr < OFS_CTRL) begin
          prdata[SEL_W-1:0] <= sel[paddr[4:2]];
        end else if (paddr == OFS_CTRL) begin
          prdata[3:0] <= ctrl;
        end else if (paddr == OFS_STAT) begin
          prdata[STAT_W-1:0] <= {ls == LS_RUN, out_frozen, ref_frozen, inch_override, reverse,
                                 run, ramp_stop, dc_hold_brake, quick_stop, coast};
        end else if (paddr == OFS_FREF) begin
          prdata[VAL_W-1:0] <= ref_hold;
        end else if (paddr == OFS_FOUT) begin
          prdata[VAL_W-1:0] <= freq_hold;
        end else if (paddr == OFS_AUX) begin
          prdata[AUX_W-1:0] <= aux_level;
        end
      end
    end
  end
endmodule : ddifd_top
`default_nettype wire

/* ddifd_pkg.sv */
// Purpose: constants and types for the digital input function decoder
// Assumes: 200 MHz pclk, five digital input terminals, 6-bit selector codes
// Notes: Behaviour
// Behaviour
// - each of five terminals has its own function selector register
// - code 0 makes the terminal ignored entirely
// - code 1 clears an active alarm on rising edge
// - trip-locked alarms are never cleared from a terminal
// - code 2 low coasts the motor at once
// - code 3 low coasts; falling edge clears the alarm
// - code 4 low starts quick-stop ramp down
// - code 5 low brakes with DC, only if time and voltage nonzero
// - code 6 low ramps motor down to standstill
// - code 7 high runs, low stops
// - code 8 pulse held 14 ms latches start unless stopped; stop cancels
// - code 9 high reverses without starting; off in closed loop
// - code 10 starts and reverses; other start not used with it; off closed loop
// - code 11 allows only clockwise, code 12 only anticlockwise
// - code 13 forces jog unless coast, quick stop or DC brake
// - code 14 freezes reference; only speed up/down change it; kept on stop
// - code 15 holds output frequency; only speed up/down change it
// - codes 19-24 and 31-33 decode to auxiliary function levels
// - codes 26-27 first two terminals; 28,29,34-36 last two; 30 last only
// - pulse reference/feedback refused on fourth terminal when pulse output set
// - speed pulses need 14 ms high, 14 ms low; one step each
// - frozen output stops only on coast, quick stop or DC brake
package ddifd_pkg;
  localparam int NUM_TERM = 5;
  localparam int SEL_W = 6;
  localparam int VAL_W = 16;
  localparam int CNT_W = 22;
  localparam int CLK_KHZ = 200000;
  localparam int PULSE_MIN_MS = 14;
  localparam int PULSE_MIN_CYC = PULSE_MIN_MS * CLK_KHZ;

  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_RESET = 6'h01;
  localparam logic [5:0] FN_COAST_LOW = 6'h02;
  localparam logic [5:0] FN_CLEAR_AND_FREEWHEEL_LOW = 6'h03;
  localparam logic [5:0] FN_QSTOP_LOW = 6'h04;
  localparam logic [5:0] FN_DC_HOLD_BRAKE_LOW = 6'h05;
  localparam logic [5:0] FN_STOP_LOW = 6'h06;
  localparam logic [5:0] FN_START = 6'h07;
  localparam logic [5:0] FN_LATCH_START = 6'h08;
  localparam logic [5:0] FN_REVERSE = 6'h09;
  localparam logic [5:0] FN_START_REV = 6'h0a;
  localparam logic [5:0] FN_FWD_ONLY = 6'h0b;
  localparam logic [5:0] FN_REV_ONLY = 6'h0c;
  localparam logic [5:0] FN_INCH_OVERRIDE = 6'h0d;
  localparam logic [5:0] FN_HOLD_REF = 6'h0e;
  localparam logic [5:0] FN_HOLD_OUT = 6'h0f;
  localparam logic [5:0] FN_SPEED_UP = 6'h10;
  localparam logic [5:0] FN_SPEED_DOWN = 6'h11;
  localparam logic [5:0] FN_AUX_BASE = 6'h13;
  localparam logic [5:0] FN_GAP = 6'h19;
  localparam logic [5:0] FN_ACCURATE_HALT_LOW = 6'h1a;
  localparam logic [5:0] FN_PRECISE_SS = 6'h1b;
  localparam logic [5:0] FN_PULSE_REF = 6'h1c;
  localparam logic [5:0] FN_PULSE_FB = 6'h1d;
  localparam logic [5:0] FN_PULSE_IN = 6'h1e;
  localparam logic [5:0] FN_RESET_START = 6'h21;
  localparam logic [5:0] FN_ENC_REF = 6'h22;
  localparam logic [5:0] FN_ENC_IN = 6'h24;
  localparam int AUX_W = 18;

  localparam logic [7:0] OFS_SEL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_FREF = 8'h1c;
  localparam logic [7:0] OFS_FOUT = 8'h20;
  localparam logic [7:0] OFS_AUX = 8'h24;
  localparam logic [29:0] SEL_RESET = {6'h00, 6'h0d, 6'h03, 6'h09, 6'h07};
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_CLOSED_LOOP = 0;
  localparam int CTRL_PULSE_OUT = 1;
  localparam int CTRL_DCB_TIME_NZ = 2;
  localparam int CTRL_DCB_VOLT_NZ = 3;
  localparam int STAT_W = 10;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b01,
    LS_RUN = 2'b10
  } ddifd_latch_type;
endpackage : ddifd_pkg

/* ddifd_qual_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ddifd_qual_if #(parameter int N = 5);
  logic [N-1:0] level;
  logic [N-1:0] long_pulse;
  modport qualifier(input level, output long_pulse);
  modport user(output level, input long_pulse);
endinterface : ddifd_qual_if
`default_nettype wire

/* ddifd_qual.sv */
// Purpose: per-terminal minimum high/low pulse qualifier
// Assumes: terminal levels already synchronous to pclk
// Notes: one pulse per high phase; a new one needs a qualified low first
`timescale 1ns/1ps
`default_nettype none
module ddifd_qual
  import ddifd_pkg::*;
#(
  parameter int N = NUM_TERM,
  parameter int MIN_CYC = PULSE_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ddifd_qual_if.qualifier q
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(MIN_CYC - 1);
  logic [N-1:0][CNT_W-1:0] cnt;
  logic [N-1:0] prev;
  logic [N-1:0] armed;
  logic [N-1:0] reached;
  logic [N-1:0] pulse;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      reached[i] = (q.level[i] == prev[i]) && (cnt[i] == LAST);
    end
  end

  // duration counter restarts on every level change and saturates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      prev <= '0;
    end else begin
      prev <= q.level;
      for (int i = 0; i < N; i++) begin
        if (q.level[i] != prev[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] != LAST) begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= '1;
      pulse <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        pulse[i] <= reached[i] & q.level[i] & armed[i];
        if (reached[i] && q.level[i]) begin
          armed[i] <= 1'b0;
        end else if (reached[i] && !q.level[i]) begin
          armed[i] <= 1'b1;
        end
      end
    end
  end

  assign q.long_pulse = pulse;
endmodule : ddifd_qual
`default_nettype wire

/* ddifd_chk.sv */
// Purpose: port checker for the digital input decoder
// Assumes: one pclk domain, presetn active low
// Notes: selectors are unseen here, so only configuration-free relations
`timescale 1ns/1ps
`default_nettype none
module ddifd_chk
  import ddifd_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_TERM-1:0] din,
  input wire logic alarm_active,
  input wire logic trip_locked,
  input wire logic [VAL_W-1:0] ref_now,
  input wire logic [VAL_W-1:0] freq_now,
  input wire logic alarm_clear,
  input wire logic coast,
  input wire logic quick_stop,
  input wire logic dc_hold_brake,
  input wire logic run,
  input wire logic inch_override,
  input wire logic ref_frozen,
  input wire logic out_frozen,
  input wire logic [VAL_W-1:0] ref_hold,
  input wire logic [VAL_W-1:0] freq_hold
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic halt;
  assign halt = coast || quick_stop || dc_hold_brake;
  a_clear_cause: assert property (
    alarm_clear |-> $past(alarm_active && !trip_locked)) else $error("clear without alarm");
  a_clear_edge: assert property (
    alarm_clear |-> $past(din) != $past(din, 2)) else $error("clear without edge");
  a_clear_pulse: assert property (
    alarm_clear |=> !alarm_clear) else $error("clear longer than a cycle");
  a_inch_block: assert property (
    inch_override |-> !halt) else $error("jog during halt");
  a_run_mask: assert property (
    run |-> !halt) else $error("run during halt");
  a_frozen_stop: assert property (
    out_frozen && $fell(run) |-> halt) else $error("frozen run dropped by plain stop");
  a_ref_step: assert property (
    ref_frozen && $past(ref_frozen) && $changed(ref_hold) |->
    ref_hold == $past(ref_hold) + 16'h1 || ref_hold == $past(ref_hold) - 16'h1)
    else $error("frozen reference jump");
  a_out_step: assert property (
    out_frozen && $past(out_frozen) && $changed(freq_hold) |->
    freq_hold == $past(freq_hold) + 16'h1 || freq_hold == $past(freq_hold) - 16'h1)
    else $error("frozen output jump");
  a_ref_entry: assert property (
    $rose(ref_frozen) |-> ref_hold == $past(ref_now)) else $error("reference not captured");
  a_out_entry: assert property (
    $rose(out_frozen) |-> freq_hold == $past(freq_now)) else $error("output not captured");
endmodule : ddifd_chk
bind ddifd_top ddifd_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.pclk(pclk), .presetn(presetn),
  .din(din), .alarm_active(alarm_active), .trip_locked(trip_locked), .ref_now(ref_now),
  .freq_now(freq_now), .alarm_clear(alarm_clear), .coast(coast), .quick_stop(quick_stop),
  .dc_hold_brake(dc_hold_brake), .run(run), .inch_override(inch_override),
  .ref_frozen(ref_frozen), .out_frozen(out_frozen), .ref_hold(ref_hold),
  .freq_hold(freq_hold));
`default_nettype wire

/* ddifd_term_drv.sv */
// Purpose: external controller driving the five terminals
// Assumes: levels change just after a rising pclk edge
// Notes: widths come from the caller, so a short pulse is a deliberate break
`timescale 1ns/1ps
`default_nettype none
module ddifd_term_drv
  import ddifd_pkg::*;
(
  input wire logic pclk,
  output logic [NUM_TERM-1:0] din
);
  initial din = '0;
  // patterns never raise two start sources together
  task put(input logic [NUM_TERM-1:0] v);
    @(posedge pclk);
    din <= v;
  endtask : put
  task pulse(input int i, input int hi, input int lo);
    @(posedge pclk);
    din[i] <= 1'b1;
    repeat (hi) @(posedge pclk);
    din[i] <= 1'b0;
    repeat (lo) @(posedge pclk);
  endtask : pulse
endmodule : ddifd_term_drv
`default_nettype wire

/* ddifd_top_tb.sv */
// Purpose: self-checking bench for the digital input decoder
// Assumes: qualifier shortened to PC cycles
// Notes: selectors are written over apb at the start of each test except t_reset, which only reads them
`timescale 1ns/1ps
`default_nettype none
module ddifd_top_tb;
  import ddifd_pkg::*;
  localparam int PC = 8;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic alarm_active;
  logic trip_locked;
  logic [VAL_W-1:0] ref_now;
  logic [VAL_W-1:0] freq_now;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [NUM_TERM-1:0] din;
  logic alarm_clear, coast, quick_stop, dc_hold_brake, ramp_stop, run, reverse;
  logic inch_override, ref_frozen, out_frozen;
  logic [VAL_W-1:0] ref_hold, freq_hold;
  logic [AUX_W-1:0] aux_level;
  int failures = 0;
  int compares = 0;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ddifd_top #(.PULSE_CYC(PC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din(din), .alarm_active(alarm_active),
    .trip_locked(trip_locked), .ref_now(ref_now), .freq_now(freq_now),
    .alarm_clear(alarm_clear), .coast(coast), .quick_stop(quick_stop),
    .dc_hold_brake(dc_hold_brake), .ramp_stop(ramp_stop), .run(run), .reverse(reverse),
    .inch_override(inch_override), .ref_frozen(ref_frozen), .out_frozen(out_frozen),
    .ref_hold(ref_hold), .freq_hold(freq_hold), .aux_level(aux_level));
  ddifd_term_drv drv (.pclk(pclk), .din(din));
  task end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  // the master waits for pready itself; the bound only guards a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask : apb
  task cfg(input logic [29:0] s);
    for (int i = 0; i < NUM_TERM; i++) begin
      apb(1'b1, OFS_SEL0 + 8'(4 * i), {26'h0, s[6*i+:6]});
    end
  endtask : cfg
  task clears(input logic [NUM_TERM-1:0] v, input logic [31:0] exp);
    int n;
    n = 0;
    drv.put(v);
    repeat (4) begin
      tick(1);
      n += int'(alarm_clear === 1'b1);
    end
    chk(n, exp);
  endtask : clears
  task t_reset;
    for (int i = 0; i < NUM_TERM; i++) begin
      apb(1'b0, OFS_SEL0 + 8'(4 * i), 32'h0);
      chk(rd, {26'h0, SEL_RESET[6*i+:6]});
    end
    apb(1'b0, 8'h28, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    chk(coast, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task t_start;
    cfg({6'h00, 6'h00, 6'h00, 6'h00, 6'h07});
    drv.put(5'b10000);
    tick(1);
    chk({coast, run}, 2'b00);
    drv.put(5'b00001);
    tick(1);
    chk(run, 1'b1);
    drv.put(5'b00000);
    tick(1);
    chk(run, 1'b0);
    $display("test start done");
  endtask : t_start
  task t_latch;
    cfg({6'h00, 6'h00, 6'h00, 6'h06, 6'h08});
    drv.put(5'b00010);
    drv.pulse(0, 4, PC + 4);
    tick(1);
    chk(run, 1'b0);
    drv.pulse(0, PC + 4, PC + 4);
    tick(1);
    chk(run, 1'b1);
    drv.put(5'b00000);
    tick(1);
    chk(run, 1'b0);
    $display("test latch done");
  endtask : t_latch
  task t_alarm;
    cfg({6'h00, 6'h00, 6'h03, 6'h01, 6'h00});
    @(posedge pclk);
    alarm_active <= 1'b1;
    clears(5'b00010, 1);
    clears(5'b00000, 0);
    trip_locked <= 1'b1;
    clears(5'b00010, 0);
    clears(5'b00000, 0);
    trip_locked <= 1'b0;
    clears(5'b00100, 0);
    chk(coast, 1'b0);
    clears(5'b00000, 1);
    chk(coast, 1'b1);
    alarm_active <= 1'b0;
    $display("test alarm done");
  endtask : t_alarm
  task t_stops;
    logic [4:0] ex [2:6];
    ex = '{5'h10, 5'h10, 5'h08, 5'h04, 5'h03};
    apb(1'b1, OFS_CTRL, 32'hc);
    for (int c = 2; c <= 6; c++) begin
      cfg({6'h00, 6'h0d, 6'(c), 6'h00, 6'h00});
      drv.put(5'b01000);
      tick(1);
      chk({coast, quick_stop, dc_hold_brake, ramp_stop, inch_override}, ex[c]);
    end
    // brake voltage zero disables the brake
    apb(1'b1, OFS_CTRL, 32'h4);
    cfg({6'h00, 6'h0d, 6'h05, 6'h00, 6'h00});
    tick(1);
    chk({dc_hold_brake, inch_override}, 2'b01);
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("test stops done");
  endtask : t_stops
  task t_freeze;
    cfg({6'h06, 6'h0e, 6'h07, 6'h10, 6'h0f});
    @(posedge pclk);
    ref_now <= 16'h0200;
    freq_now <= 16'h0100;
    drv.put(5'b10100);
    tick(1);
    chk(run, 1'b1);
    drv.put(5'b11101);
    tick(1);
    chk({ref_frozen, out_frozen, ref_hold, freq_hold}, 34'h302000100);
    apb(1'b1, OFS_FREF, 32'h1234);
    drv.pulse(1, PC + 4, PC + 4);
    tick(1);
    chk({ref_hold, freq_hold}, 32'h02010101);
    apb(1'b1, OFS_SEL0 + 8'h4, 32'h11);
    drv.pulse(1, PC + 4, PC + 4);
    tick(1);
    chk({ref_hold, freq_hold}, 32'h02000100);
    drv.put(5'b01101);
    tick(2);
    chk(run, 1'b1);
    apb(1'b1, OFS_SEL0 + 8'h10, 32'h2);
    tick(1);
    chk({run, ref_hold}, 17'h00200);
    drv.put(5'b00000);
    $display("test freeze done");
  endtask : t_freeze
  task t_refuse;
    cfg({6'h1e, 6'h09, 6'h1a, 6'h1a, 6'h07});
    drv.put(5'b01011);
    tick(1);
    chk({run, reverse}, 2'b11);
    apb(1'b1, OFS_CTRL, 32'h1);
    tick(1);
    chk(reverse, 1'b0);
    drv.put(5'b01001);
    tick(1);
    chk(run, 1'b0);
    apb(1'b1, OFS_SEL0 + 8'h4, 32'h3f);
    tick(1);
    chk(run, 1'b1);
    apb(1'b1, OFS_SEL0 + 8'h8, 32'h13);
    drv.put(5'b01101);
    tick(1);
    chk(aux_level, 18'h00001);
    $display("test refuse done");
  endtask : t_refuse
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    alarm_active <= 1'b0;
    trip_locked <= 1'b0;
    ref_now <= 16'h0000;
    freq_now <= 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
    t_reset();
    t_start();
    t_latch();
    t_alarm();
    t_stops();
    t_freeze();
    t_refuse();
    end_of_test();
  end
endmodule : ddifd_top_tb
`default_nettype wire
